// *** src/thermal_gate_map.vh ***
// Constants for the thermal gate and group stagger block
`ifndef THERMAL_GATE_MAP_VH
`define THERMAL_GATE_MAP_VH
`define CHANNEL_COUNT      16
`define GROUP_COUNT        4
`define STATUS_WIDTH       17
`define STATUS_FLAG_BIT    16
`define GROUP_DELAY_CYCLES 4
`define FLAG_RESET         1'b0
`define GATE_RESET         1'b0
`endif

// *** src/group_stagger.v ***
// Tapped delay line that staggers enable edges of four channel groups
`timescale 1ns/1ps
`include "thermal_gate_map.vh"
module group_stagger #(
  parameter GROUPS = `GROUP_COUNT,
  parameter DELAY  = `GROUP_DELAY_CYCLES
) (
  input  wire              clk,
  input  wire              resetn,
  input  wire              enable_in,
  output wire [GROUPS-1:0] group_enable
);
  reg [GROUPS*DELAY-1:0] tap_reg;
  reg [GROUPS-1:0]       group_reg;
  wire [GROUPS*DELAY-1:0] tap_next;

  // Same delay line for rising and falling edges, so off staggers like on
  assign tap_next = {tap_reg[GROUPS*DELAY-2:0], enable_in};

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tap_reg <= {(GROUPS*DELAY){`GATE_RESET}};
    end else begin
      tap_reg <= tap_next;
    end
  end

  genvar g;
  generate
    for (g = 0; g < GROUPS; g = g + 1) begin : grp
      always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          group_reg[g] <= `GATE_RESET;
        end else begin
          group_reg[g] <= tap_reg[g*DELAY];
        end
      end
    end
  endgenerate

  assign group_enable = group_reg;
endmodule // group_stagger

// *** src/thermal_gate.v ***
// Thermal shutdown gating and staggered group enables for 16 sink outputs
// What this block does
// - Overheat forces all sinks off, flag set
// - Flag high holds every sink off
// - Flag clears when overheat indication drops
// - After shutdown, sinks stay off this cycle
// - Re-enable on first shift clock after blank low
// - Four groups: channel index modulo four
// - Groups turn on in order with delay
// - PWM turn-off staggered the same as turn-on; run drop turns all sinks off at once
// - Blank high keeps every sink off
// - Status word loads flag plus open bits
`timescale 1ns/1ps
`include "thermal_gate_map.vh"
module thermal_gate #(
  parameter CHANNELS = `CHANNEL_COUNT,
  parameter GROUPS   = `GROUP_COUNT,
  parameter DELAY    = `GROUP_DELAY_CYCLES
) (
  input  wire                     clk,
  input  wire                     resetn,
  input  wire                     overheat_shutdown,
  input  wire                     blank,
  input  wire                     grayscale_shift_clock,
  input  wire                     grayscale_latch_strobe_n,
  input  wire [CHANNELS-1:0]      pwm_on,
  input  wire [CHANNELS-1:0]      open_led_detect,
  output reg  [CHANNELS-1:0]      sink_channel_n,
  output reg                      thermal_error_flag,
  output reg  [`STATUS_WIDTH-1:0] status_readback_word,
  output reg                      status_load_pulse
);
  // One-hot states of the grayscale cycle gate
  localparam [2:0] ST_IDLE  = 3'b001;
  localparam [2:0] ST_ARMED = 3'b010;
  localparam [2:0] ST_RUN   = 3'b100;
  // Pipe length per channel; the last group needs the longest pipe
  localparam PIPE = (GROUPS - 1) * DELAY + 1;

  // Control pin inputs pass two flops before any logic reads them
  reg [1:0]               heat_sync_reg;
  reg [1:0]               blank_sync_reg;
  reg [1:0]               sclk_sync_reg;
  reg [1:0]               lat_sync_reg;
  reg                     blank_prev_reg;
  reg                     sclk_prev_reg;
  reg                     lat_prev_reg;
  // Gate state and its next value
  reg [2:0]               state_reg;
  reg [2:0]               state_next;
  reg                     load_pend_reg;
  reg [CHANNELS*PIPE-1:0] pipe_reg;
  wire                    heat;
  wire                    hot;
  wire                    blank_s;
  wire                    blank_fall;
  wire                    sclk_rise;
  wire                    lat_fall;
  wire                    run;
  wire [GROUPS-1:0]       group_enable;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      heat_sync_reg  <= 2'b00;
      blank_sync_reg <= 2'b11;
      sclk_sync_reg  <= 2'b00;
      lat_sync_reg   <= 2'b11;
    end else begin
      heat_sync_reg  <= {heat_sync_reg[0], overheat_shutdown};
      blank_sync_reg <= {blank_sync_reg[0], blank};
      sclk_sync_reg  <= {sclk_sync_reg[0], grayscale_shift_clock};
      lat_sync_reg   <= {lat_sync_reg[0], grayscale_latch_strobe_n};
    end
  end

  // Previous samples start at the idle levels so reset makes no false edge
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      blank_prev_reg <= 1'b1;
      sclk_prev_reg  <= 1'b0;
      lat_prev_reg   <= 1'b1;
    end else begin
      blank_prev_reg <= blank_sync_reg[1];
      sclk_prev_reg  <= sclk_sync_reg[1];
      lat_prev_reg   <= lat_sync_reg[1];
    end
  end

  // Edges of the synced pins, two clocks after the pin moves
  assign heat       = heat_sync_reg[1];
  assign hot        = heat | thermal_error_flag;
  assign blank_s    = blank_sync_reg[1];
  assign blank_fall = ~blank_sync_reg[1] & blank_prev_reg;
  assign sclk_rise  = sclk_sync_reg[1] & ~sclk_prev_reg;
  assign lat_fall   = ~lat_sync_reg[1] & lat_prev_reg;
  assign run        = (state_reg == ST_RUN);

  // Flag mirrors the synced indication; hysteresis lives in the sensor
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      thermal_error_flag <= `FLAG_RESET;
    end else if (heat) begin
      thermal_error_flag <= 1'b1;
    end else begin
      thermal_error_flag <= 1'b0;
    end
  end

  // Arming needs a fresh blank fall with the flag clear, so a part that
  // cools while blank stays low sits out the rest of that cycle.
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        // Blank falling while hot is ignored; a later fall is needed
        if (!hot && blank_fall) begin
          state_next = ST_ARMED;
        end
      end
      ST_ARMED: begin
        // Blank back high or a new shutdown cancels the pending start
        if (hot || blank_s) begin
          state_next = ST_IDLE;
        end else if (sclk_rise) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        // All sinks drop together once run drops; the run term gates them directly
        if (hot) begin
          state_next = ST_IDLE;
        end else if (blank_s) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // Illegal codes fall back to idle through the default branch
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // One delay line staggers the run enable for both edges
  group_stagger #(
    .GROUPS (GROUPS),
    .DELAY  (DELAY)
  ) u_stagger (
    .clk          (clk),
    .resetn       (resetn),
    .enable_in    (run),
    .group_enable (group_enable)
  );

  // Each request is delayed by its group's share of the stagger, so PWM
  // on and off edges spread over the groups alike
  genvar c;
  generate
    for (c = 0; c < CHANNELS; c = c + 1) begin : dly
      always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          pipe_reg[c*PIPE +: PIPE] <= {PIPE{`GATE_RESET}};
        end else begin
          pipe_reg[c*PIPE +: PIPE] <= {pipe_reg[c*PIPE +: PIPE-1], pwm_on[c]};
        end
      end
    end
  endgenerate

  // Hot and blank gate directly: a shutdown must not wait for the drain
  generate
    for (c = 0; c < CHANNELS; c = c + 1) begin : ch
      always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          sink_channel_n[c] <= `GATE_RESET;
        end else begin
          sink_channel_n[c] <= pipe_reg[c*PIPE + (c % GROUPS) * DELAY]
                               & group_enable[c % GROUPS] & run
                               & ~hot
                               & ~blank_s;
        end
      end
    end
  endgenerate

  // Status capture on the first shift edge after the strobe falls
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      load_pend_reg <= 1'b0;
    end else if (lat_fall) begin
      // Strobe fall wins over a shift edge in the same cycle
      load_pend_reg <= 1'b1;
    end else if (load_pend_reg && sclk_rise) begin
      load_pend_reg <= 1'b0;
    end
  end

  // Word keeps its value until the next capture
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      status_readback_word <= {`STATUS_WIDTH{1'b0}};
    end else if (load_pend_reg && sclk_rise && !lat_fall) begin
      status_readback_word <= {thermal_error_flag, open_led_detect};
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      status_load_pulse <= 1'b0;
    end else begin
      status_load_pulse <= load_pend_reg & sclk_rise & ~lat_fall;
    end
  end
endmodule // thermal_gate

// *** verif/thermal_gate_checker.sv ***
// Checker for thermal gate outputs
`timescale 1ns/1ps
module thermal_gate_checker #(parameter CHANNELS = 16) (
  input wire                clk,
  input wire                resetn,
  input wire                overheat_shutdown,
  input wire                blank,
  input wire [CHANNELS-1:0] pwm_on,
  input wire [CHANNELS-1:0] open_led_detect,
  input wire [CHANNELS-1:0] sink_channel_n,
  input wire                thermal_error_flag,
  input wire [16:0]         status_readback_word,
  input wire                status_load_pulse
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_stag;
    !sink_channel_n[1] [*4] ##1 sink_channel_n[1] ##4 sink_channel_n[2] ##4 sink_channel_n[3];
  endsequence
  AST_SET: assert property (overheat_shutdown [*4] |-> thermal_error_flag)
    else $error("flag not set");
  AST_CLR: assert property (!overheat_shutdown [*4] |-> !thermal_error_flag)
    else $error("flag not cleared");
  AST_HOLD: assert property (thermal_error_flag |-> sink_channel_n == 0)
    else $error("sink on while hot");
  AST_BLANK: assert property (blank [*5] |-> sink_channel_n == 0)
    else $error("sink on while blank");
  AST_GROUP: assert property (&pwm_on |-> sink_channel_n == {4{sink_channel_n[3:0]}})
    else $error("group split");
  AST_ORDER: assert property ($rose(sink_channel_n[0]) && &pwm_on |-> s_stag)
    else $error("stagger wrong");
  AST_WORD: assert property (status_load_pulse |-> status_readback_word[15:0] == open_led_detect)
    else $error("open bits wrong");
  AST_PULSE: assert property (status_load_pulse |=> !status_load_pulse)
    else $error("pulse too long");
endmodule // thermal_gate_checker
bind thermal_gate thermal_gate_checker #(.CHANNELS(CHANNELS)) i_chk (.clk, .resetn,
  .overheat_shutdown, .blank, .pwm_on, .open_led_detect, .sink_channel_n,
  .thermal_error_flag, .status_readback_word, .status_load_pulse);

// *** verif/display_ctrl.sv ***
// Display controller model driving blank, shift clock and latch strobe
`timescale 1ns/1ps
module display_ctrl (
  input wire    clk,
  output logic  blank = 1'b1,
  output logic  grayscale_shift_clock = 1'b0,
  output logic  grayscale_latch_strobe_n = 1'b1
);
  task automatic set_blank(input logic v);
    @(posedge clk) blank <= v;
  endtask
  // Clock parks low between frames
  task automatic pulses(input int n);
    repeat (2 * n) begin
      repeat (4) @(posedge clk);
      grayscale_shift_clock <= ~grayscale_shift_clock;
    end
  endtask
  task automatic strobe;
    @(posedge clk) grayscale_latch_strobe_n <= 1'b0;
    repeat (4) @(posedge clk);
    grayscale_latch_strobe_n <= 1'b1;
  endtask
endmodule // display_ctrl

// *** verif/tb_top.sv ***
// Testbench for the thermal gate block
`timescale 1ns/1ps
module tb_top;
  logic        clk = 0, resetn = 0, heat = 0;
  wire         blank, sclk, lat_n, flag, pulse;
  wire  [15:0] sink;
  wire  [16:0] word;
  int          err_total = 0, tests_run = 0;
  logic [15:0] pwm = 16'hffff, opens = 16'h5a3c;
  always #10 clk = ~clk;
  display_ctrl i_ctrl (.clk(clk), .blank(blank), .grayscale_shift_clock(sclk),
    .grayscale_latch_strobe_n(lat_n));
  thermal_gate i_dut (.clk(clk), .resetn(resetn), .overheat_shutdown(heat), .blank(blank),
    .grayscale_shift_clock(sclk), .grayscale_latch_strobe_n(lat_n), .pwm_on(pwm),
    .open_led_detect(opens), .sink_channel_n(sink), .thermal_error_flag(flag),
    .status_readback_word(word), .status_load_pulse(pulse));
  task automatic chk(input logic [16:0] g, e);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("Error %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic await(input logic [16:0] e, input bit f);
    for (int n = 0; n < 80; n++) begin
      @(posedge clk) #1;
      if ((f ? {16'h0, flag} : {1'b0, sink}) === e) return;
    end
    chk(f ? {16'h0, flag} : {1'b0, sink}, e);
    stop_test;
  endtask
  task automatic t_run;
    i_ctrl.set_blank(0);
    i_ctrl.pulses(1);
    await(17'h01111, 0);
    repeat (4) @(posedge clk) #1;
    chk(sink, 16'h3333);
    repeat (8) @(posedge clk) #1;
    chk(sink, 16'hffff);
  endtask
  task automatic t_heat;
    @(posedge clk) heat <= 1;
    await(17'h1, 1);
    i_ctrl.strobe;
    i_ctrl.pulses(2);
    chk(word, {1'b1, 16'h5a3c});
    chk(sink, 16'h0);
    heat <= 0;
    await(17'h0, 1);
    i_ctrl.pulses(1);
    repeat (20) @(posedge clk) #1;
    chk(sink, 16'h0);
    i_ctrl.set_blank(1);
    i_ctrl.set_blank(0);
    i_ctrl.pulses(1);
    await(17'h0ffff, 0);
  endtask
  task automatic t_off;
    @(posedge clk) pwm <= 16'h0000;
    await(17'h0eeee, 0);
    repeat (4) @(posedge clk) #1;
    chk(sink, 16'hcccc);
    @(posedge clk) pwm <= 16'hffff;
    await(17'h0ffff, 0);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    resetn <= 1;
    t_run;
    i_ctrl.set_blank(1);
    await(17'h0, 0);
    i_ctrl.set_blank(0);
    i_ctrl.pulses(1);
    await(17'h0ffff, 0);
    t_off;
    t_heat;
    stop_test;
  end
endmodule // tb_top
